// file: pkg/adcsr_pkg.sv
// constants, types and timing for the serial readout controller
// assumes a single 20 MHz core clock; all pins synchronous to it
package adcsr_pkg;

  localparam int unsigned CLK_NS       = 50;
  localparam int unsigned CONV60_NS    = 133_000_000;
  localparam int unsigned CONV50_NS    = 160_000_000;
  localparam int unsigned CONV60_CYC   = CONV60_NS / CLK_NS;
  localparam int unsigned CONV50_CYC   = CONV50_NS / CLK_NS;
  localparam int unsigned DOUT_MAX_NS  = 1_670_000;
  localparam int unsigned OSC_PER_DOUT = 256;
  localparam int unsigned INT_TICK_CYC = DOUT_MAX_NS / (OSC_PER_DOUT * CLK_NS);
  localparam int unsigned EXT_MIN_HZ   = 2560;
  localparam int unsigned DET_CYC      = 1_000_000_000 / (EXT_MIN_HZ * CLK_NS);
  localparam int unsigned EXT_CONV_TCK = 20510;
  localparam int unsigned SCK_DIV      = 8;
  localparam int unsigned SCK_HALF     = SCK_DIV / 2;
  localparam int unsigned FRAME_BITS   = 32;
  localparam int unsigned RESULT_W     = 30;
  localparam int unsigned CNT_W        = 24;
  localparam logic [31:0] FRAME_RST    = 32'h8000_0000;
  localparam logic        FILLER_BIT   = 1'b0;
  localparam logic [4:0]  LAST_BIT     = 5'h1F;

  typedef enum logic [1:0] {
    ST_CONVERT = 2'b00,
    ST_SLEEP   = 2'b01,
    ST_DATA    = 2'b10
  } adcsr_state_e;

endpackage : adcsr_pkg

// file: pkg/adcsr_stream_if.sv
// valid/ready word stream between the controller's own modules
// assumes both ends on the core clock
`timescale 1ns/100ps
interface adcsr_stream_if #(parameter int unsigned W = 30);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : adcsr_stream_if

// file: logic/adcsr_buf.sv
// two-entry buffer for conversion results
// assumes consumer may hold ready low for any length of time
`timescale 1ns/100ps
module adcsr_buf #(
  parameter int unsigned W     = 30,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input  wire logic     core_clk,
  input  wire logic     reset_n,
  // streams
  adcsr_stream_if.snk   in_p,
  adcsr_stream_if.src   out_p
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_p.ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_p.valid = (cnt_q != '0);
  assign out_p.data  = mem_q[rd_q];
  assign push        = in_p.valid & in_p.ready;
  assign pop         = out_p.valid & out_p.ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_p.data;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : adcsr_buf

// file: logic/adcsr_osc.sv
// conversion clock source: internal tick or detected external oscillator
// assumes the select pin is already synchronous to the core clock
`timescale 1ns/100ps
module adcsr_osc
  import adcsr_pkg::*;
#(
  parameter int unsigned INT_TICK = adcsr_pkg::INT_TICK_CYC,
  parameter int unsigned DET      = adcsr_pkg::DET_CYC
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // select pin
  input  wire logic rejection_select,
  // conversion clock
  output logic      tick,
  output logic      ext_present
);
  logic        sel_q;
  logic [15:0] gap_q;
  logic [15:0] div_q;
  logic        edge_r;

  assign edge_r = rejection_select & ~sel_q;

  // an edge within the detection window means an oscillator is present
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q       <= 1'b0;
      // starts saturated: a lone edge after reset is not an oscillator
      gap_q       <= 16'(DET);
      ext_present <= 1'b0;
    end else begin
      sel_q <= rejection_select;
      if (edge_r) begin
        gap_q       <= '0;
        ext_present <= (gap_q < 16'(DET));
      end else if (gap_q >= 16'(DET)) begin
        ext_present <= 1'b0;
      end else begin
        gap_q <= gap_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
      tick  <= 1'b0;
    end else if (ext_present) begin
      div_q <= '0;
      tick  <= edge_r;
    end else begin
      tick  <= (div_q == 16'(INT_TICK - 1));
      div_q <= (div_q == 16'(INT_TICK - 1)) ? '0 : div_q + 16'h0001;
    end
  end
endmodule : adcsr_osc

// file: logic/adcsr_ctrl.sv
// conversion state control and three-wire serial readout
// assumes pins are synchronous to core_clk and an undriven clock pin
// reads high through the pad pull-up; results arrive as a stream
`timescale 1ns/100ps
module adcsr_ctrl #(
  parameter int unsigned CONV60 = adcsr_pkg::CONV60_CYC,
  parameter int unsigned CONV50 = adcsr_pkg::CONV50_CYC,
  parameter int unsigned DET    = adcsr_pkg::DET_CYC,
  parameter int unsigned RES_W  = adcsr_pkg::RESULT_W
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // serial pins
  input  wire logic             cs_n,
  input  wire logic             sck_in,
  output logic                  sck_out,
  output logic                  sck_oe_n,
  output logic                  sdo_out,
  output logic                  sdo_oe_n,
  // rejection select or external oscillator
  input  wire logic             rejection_select,
  // modulator side
  output logic                  conv_start,
  input  wire logic             res_valid,
  input  wire logic [RES_W-1:0] res_data,
  output logic                  res_ready,
  // status
  output logic                  conv_busy,
  output logic                  data_out_active,
  output logic                  int_sck_mode,
  output logic                  ext_osc_active
);
  import adcsr_pkg::*;

  adcsr_state_e     state_q;
  logic             por_q;
  logic             int_sck_q;
  logic             sck_drv_q;
  logic             cs_q;
  logic             sck_prev_q;
  logic             sck_gen_q;
  logic [1:0]       half_q;
  logic [4:0]       bit_cnt_q;
  logic [31:0]      shreg_q;
  logic [CNT_W-1:0] conv_cnt_q;
  logic             start_q;
  logic             conv_tick;
  logic             ext_osc;
  logic             cs_fall;
  logic             cs_rise;
  logic             sck_eff;
  logic             sck_rise;
  logic             sck_fall;
  logic             conv_done;
  logic             load;
  logic             last_fall;
  logic             start_conv;
  logic             gen_run;

  adcsr_stream_if #(.W(RES_W)) in_s ();
  adcsr_stream_if #(.W(RES_W)) out_s ();

  assign in_s.valid = res_valid;
  assign in_s.data  = res_data;
  assign res_ready  = in_s.ready;

  adcsr_buf #(
    .W     (RES_W),
    .DEPTH (2)
  ) u_buf (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .in_p     (in_s.snk),
    .out_p    (out_s.src)
  );

  adcsr_osc #(
    .INT_TICK (INT_TICK_CYC),
    .DET      (DET)
  ) u_osc (
    .core_clk         (core_clk),
    .reset_n          (reset_n),
    .rejection_select (rejection_select),
    .tick             (conv_tick),
    .ext_present      (ext_osc)
  );

  // edge detection on chip select and the effective serial clock
  assign cs_fall   = cs_q & ~cs_n;
  assign cs_rise   = ~cs_q & cs_n;
  assign sck_eff   = int_sck_q ? sck_gen_q : sck_in;
  // edges while deselected are ignored by the shifter
  assign sck_rise  = sck_eff & ~sck_prev_q & ~cs_n & ~cs_fall;
  assign sck_fall  = ~sck_eff & sck_prev_q & ~cs_n & ~cs_fall;
  assign last_fall = (state_q == ST_DATA) & sck_fall & (bit_cnt_q == LAST_BIT);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_q       <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      cs_q       <= cs_n;
      sck_prev_q <= sck_eff;
    end
  end

  // serial clock mode: first cycle after reset, then each chip select fall
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      por_q     <= 1'b0;
      int_sck_q <= 1'b1;
    end else if (!por_q) begin
      por_q     <= 1'b1;
      int_sck_q <= sck_in;
    end else if (cs_fall) begin
      int_sck_q <= sck_in;
    end
  end

  // drive starts a cycle after selection so the sampled pin is the host's
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_drv_q <= 1'b0;
    end else begin
      sck_drv_q <= int_sck_q & ~cs_n & ~cs_fall;
    end
  end

  assign sck_oe_n = ~sck_drv_q;
  assign sck_out  = sck_gen_q;

  // internal serial clock: conversion clock divided by eight
  assign gen_run = sck_drv_q & ~cs_n & (state_q != ST_CONVERT);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_gen_q <= 1'b0;
      half_q    <= '0;
    end else if (!gen_run) begin
      sck_gen_q <= 1'b0;
      half_q    <= '0;
    end else if (conv_tick) begin
      if (half_q == 2'(SCK_HALF - 1)) begin
        half_q    <= '0;
        sck_gen_q <= ~sck_gen_q;
      end else begin
        half_q <= half_q + 2'h1;
      end
    end
  end

  // convert timer; source switch mid-conversion only spoils that result
  always_comb begin
    if (ext_osc) begin
      conv_done = (conv_cnt_q >= CNT_W'(EXT_CONV_TCK));
    end else if (rejection_select) begin
      conv_done = (conv_cnt_q >= CNT_W'(CONV50));
    end else begin
      conv_done = (conv_cnt_q >= CNT_W'(CONV60));
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_cnt_q <= '0;
    end else if (state_q != ST_CONVERT || start_conv) begin
      conv_cnt_q <= '0;
    end else if (!conv_done && (!ext_osc || conv_tick)) begin
      conv_cnt_q <= conv_cnt_q + 1'b1;
    end
  end

  // completion waits for the modulator result if it is late
  assign out_s.ready = (state_q == ST_CONVERT) & conv_done;
  assign load        = out_s.valid & out_s.ready;
  assign start_conv  = ((state_q == ST_DATA) & cs_rise) | last_fall | ~por_q;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_CONVERT;
    end else begin
      case (state_q)
        ST_CONVERT: begin
          if (load) begin
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (sck_rise) begin
            state_q <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (cs_rise) begin
            state_q <= ST_CONVERT;
          end else if (last_fall) begin
            state_q <= ST_CONVERT;
          end
        end
        default: begin
          state_q <= ST_CONVERT;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_q <= '0;
    end else if (state_q != ST_DATA) begin
      bit_cnt_q <= '0;
    end else if (sck_fall) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // frame register: its top bit is the line level in every state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shreg_q <= FRAME_RST;
    end else if (load) begin
      shreg_q <= {1'b0, FILLER_BIT, out_s.data};
    end else if (start_conv) begin
      shreg_q <= FRAME_RST;
    end else if (state_q == ST_DATA && sck_fall) begin
      shreg_q <= {shreg_q[30:0], 1'b0};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_conv;
    end
  end

  assign sdo_out         = shreg_q[31];
  assign sdo_oe_n        = cs_n;
  assign conv_start      = start_q;
  assign conv_busy       = (state_q == ST_CONVERT);
  assign data_out_active = (state_q == ST_DATA);
  assign int_sck_mode    = int_sck_q;
  assign ext_osc_active  = ext_osc;

  a_sdo_hiz_cs: assert property (@(posedge core_clk) disable iff (!reset_n)
    cs_n |-> sdo_oe_n) else $error("data line driven while deselected");

  a_eoc_convert: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_CONVERT && por_q && !cs_n) |-> sdo_out)
    else $error("done flag low during conversion");

  a_eoc_sleep_low: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_SLEEP) |-> !sdo_out) else $error("done flag high in sleep");

  a_sleep_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_SLEEP && !sck_rise) |=> (state_q == ST_SLEEP))
    else $error("sleep left without a serial clock rise");

  a_abort_on_cs: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_DATA && cs_rise) |=> (state_q == ST_CONVERT && sdo_out && conv_start))
    else $error("chip select rise did not abort");

  a_last_fall_end: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_DATA && sck_fall && bit_cnt_q == 5'h1F) |=> (state_q == ST_CONVERT && sdo_out))
    else $error("32nd falling edge did not restart");

  a_shift_on_fall: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_DATA && sck_fall && bit_cnt_q != 5'h1F) |=> (sdo_out == $past(shreg_q[30])))
    else $error("data bit not advanced on falling edge");

  a_mode_select: assert property (@(posedge core_clk) disable iff (!reset_n)
    (por_q && $fell(cs_n)) |=> (int_sck_q == $past(sck_in)))
    else $error("clock mode not taken at chip select fall");

  a_ext_sck_input: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!int_sck_q && !$fell(cs_n)) |-> sck_oe_n) else $error("clock pin driven in external mode");

  a_convert_length: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_CONVERT && !conv_done) |=> (state_q == ST_CONVERT))
    else $error("conversion ended early");

  a_conv_ext_ticks: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_CONVERT && ext_osc && !conv_tick && !start_conv) |=> $stable(conv_cnt_q))
    else $error("conversion counted without an oscillator edge");

  a_sck_div_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    (gen_run && !conv_tick) |=> $stable(sck_gen_q))
    else $error("serial clock moved between conversion ticks");

  a_sck_low_convert: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_CONVERT) |=> !sck_out)
    else $error("serial clock not low while converting");

  a_frame_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    load |=> (shreg_q[31:30] == 2'b00 && shreg_q[29:0] == $past(out_s.data)))
    else $error("loaded frame does not match the result word");

  a_sleep_frame_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_SLEEP) |=> $stable(shreg_q))
    else $error("held result changed during sleep");

  a_data_bit_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_q == ST_DATA && !sck_fall && !cs_rise) |=> $stable(sdo_out))
    else $error("data bit changed away from a falling edge");

  a_restart_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
    last_fall |=> conv_start)
    else $error("no conversion start after the last falling edge");
endmodule : adcsr_ctrl

// file: sim/adcsr_host.sv
// host-side serial controller model facing the readout block
// assumes everything runs off core_clk; sck pin has a pull-up
`timescale 1ns/100ps
module adcsr_host (
  // clock
  input  wire logic core_clk,
  // device pins
  input  wire logic sck_out,
  input  wire logic sck_oe_n,
  input  wire logic sdo_out,
  input  wire logic sdo_oe_n,
  output logic      cs_n,
  output wire logic sck_in
);
  logic drv_en;
  logic drv_sck;
  logic sdo_pin;

  // a released data line reads inverted so a sample taken then shows up
  assign sdo_pin = sdo_oe_n ? ~sdo_out : sdo_out;

  // pull-up wins when neither side drives the pin
  assign sck_in = !sck_oe_n ? sck_out : (drv_en ? drv_sck : 1'b1);

  initial begin
    cs_n    = 1'b1;
    drv_en  = 1'b1;
    drv_sck = 1'b0;
  end

  // chip select fall; a low clock pin asks for host clocking
  task select(input logic ext);
    @(posedge core_clk);
    drv_en <= ext;
    @(posedge core_clk);
    cs_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask : select

  task deselect;
    @(posedge core_clk);
    cs_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask : deselect

  // bit is taken just before each rise; half periods kept above 2 cycles
  task ext_bits(input int n, output logic [31:0] w);
    w = '0;
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      w = {w[30:0], sdo_pin};
      @(posedge core_clk);
      drv_sck <= 1'b1;
      repeat (3) @(posedge core_clk);
      drv_sck <= 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask : ext_bits

  task int_frame(output logic [31:0] w, output int per, output logic ok);
    int   falls;
    int   t0;
    logic prev;
    w = '0;
    falls = 0;
    per = 0;
    t0 = -1;
    @(negedge core_clk);
    prev = sck_in;
    for (int t = 0; t < 40000 && falls < 32; t++) begin
      @(negedge core_clk);
      if (sck_in && !prev) begin
        w = {w[30:0], sdo_pin};
        if (t0 >= 0 && per == 0) per = t - t0;
        t0 = t;
      end
      if (!sck_in && prev) falls++;
      prev = sck_in;
    end
    ok = (falls == 32);
  endtask : int_frame
endmodule : adcsr_host

// file: sim/adcsr_ctrl_tb.sv
// self-checking bench for the serial readout controller
// assumes shortened conversion counts; host model drives the pins
`timescale 1ns/100ps
module adcsr_ctrl_tb;
  import adcsr_pkg::*;
  localparam int C60  = 400;
  localparam int C50  = 500;
  localparam int DETC = 300;
  typedef struct packed {logic sel; logic [29:0] d;} adcsr_row_s;

  logic        core_clk;
  logic        reset_n;
  logic        cs_n;
  wire         sck_in;
  logic        sck_out;
  logic        sck_oe_n;
  logic        sdo_out;
  logic        sdo_oe_n;
  logic        rejection_select;
  logic        conv_start;
  logic        res_valid;
  logic [29:0] res_data;
  logic        res_ready;
  logic        conv_busy;
  logic        data_out_active;
  logic        int_sck_mode;
  logic        ext_osc_active;
  int          miscompares = 0;
  int          n_checks = 0;
  int          run = 0;
  int          per;
  logic        ok;
  logic        ps;
  logic [31:0] w;
  adcsr_row_s  rows [4] = '{{1'b0, 30'h3FFFFFFF}, {1'b0, 30'h00000001},
                            {1'b1, 30'h15555555}, {1'b1, 30'h2AAAAAAA}};

  adcsr_ctrl #(.CONV60(C60), .CONV50(C50), .DET(DETC), .RES_W(30)) DUT (
    .core_clk(core_clk), .reset_n(reset_n), .cs_n(cs_n), .sck_in(sck_in),
    .sck_out(sck_out), .sck_oe_n(sck_oe_n), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .rejection_select(rejection_select), .conv_start(conv_start), .res_valid(res_valid),
    .res_data(res_data), .res_ready(res_ready), .conv_busy(conv_busy),
    .data_out_active(data_out_active), .int_sck_mode(int_sck_mode),
    .ext_osc_active(ext_osc_active));

  adcsr_host host (.core_clk(core_clk), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .cs_n(cs_n), .sck_in(sck_in));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // cycles spent converting since the last start pulse
  always @(posedge core_clk) begin
    if (conv_start) run <= 0;
    else if (conv_busy) run <= run + 1;
  end

  task tally_and_finish;
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task chk1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chk1

  task bail;
    miscompares++;
    tally_and_finish();
  endtask : bail

  task wait_idle;
    int k;
    for (k = 0; k < 3000 && conv_busy !== 1'b0; k++) @(negedge core_clk);
    if (k == 3000) bail();
  endtask : wait_idle

  // valid and data held until an edge that sees ready high
  task push(input logic [29:0] d);
    int k;
    @(posedge core_clk);
    res_valid <= 1'b1;
    res_data  <= d;
    for (k = 0; k < 3000; k++) begin
      @(negedge core_clk);
      if (res_ready === 1'b1) break;
    end
    if (k == 3000) bail();
    @(posedge core_clk);
    res_valid <= 1'b0;
  endtask : push

  task frame_end;
    repeat (4) @(negedge core_clk);
    chk1("sdo after last fall", 1'b1, sdo_out);
    chk1("busy after last fall", 1'b1, conv_busy);
  endtask : frame_end

  initial begin
    reset_n          = 1'b0;
    rejection_select = 1'b0;
    res_valid        = 1'b0;
    res_data         = '0;
    repeat (2) @(negedge core_clk);
    chk1("reset busy", 1'b1, conv_busy);
    chk1("reset sck enable", 1'b1, sck_oe_n);
    chk1("reset sdo enable", 1'b1, sdo_oe_n);
    @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (3) @(negedge core_clk);
    chk1("power-up mode", 1'b0, int_sck_mode);
    ps = 1'b0;
    foreach (rows[i]) begin
      @(posedge core_clk);
      rejection_select <= rows[i].sel;
      push(rows[i].d);
      host.select(1'b1);
      chk1("ext mode", 1'b0, int_sck_mode);
      chk1("converting flag", 1'b1, sdo_out);
      wait_idle();
      if (ps == rows[i].sel) chk1("conv length", 1'b1, run + 3 >= (rows[i].sel ? C50 : C60) &&
                                  run <= (rows[i].sel ? C50 : C60) + 3);
      repeat (20) @(negedge core_clk);
      chk1("done flag", 1'b0, sdo_out);
      chk1("sleep holds", 1'b0, data_out_active);
      host.ext_bits(32, w);
      chk("frame", {2'b00, rows[i].d}, w);
      frame_end();
      host.deselect();
      chk1("sdo released", 1'b1, sdo_oe_n);
      ps = rows[i].sel;
    end
    // two words fill the buffer, the third waits for a conversion end
    push(30'h2468ACE1);
    push(30'h13579BDF);
    @(negedge core_clk);
    chk1("buffer full", 1'b0, res_ready);
    push(30'h3C3C3C3C);
    host.select(1'b1);
    wait_idle();
    host.ext_bits(32, w);
    chk("frame a", {2'b00, 30'h2468ACE1}, w);
    frame_end();
    wait_idle();
    host.ext_bits(5, w);
    chk("partial b", {27'h0, 5'h02}, w);
    host.deselect();
    chk1("abort busy", 1'b1, conv_busy);
    chk1("abort data", 1'b0, data_out_active);
    host.select(1'b1);
    wait_idle();
    host.ext_bits(32, w);
    chk("frame c", {2'b00, 30'h3C3C3C3C}, w);
    frame_end();
    host.deselect();
    // undriven clock pin gives the device-clocked mode
    push(30'h1F00FF0F);
    host.select(1'b0);
    chk1("int mode", 1'b1, int_sck_mode);
    chk1("sck driven", 1'b0, sck_oe_n);
    wait_idle();
    host.int_frame(w, per, ok);
    chk1("32 cycles", 1'b1, ok);
    chk("int frame", {2'b00, 30'h1F00FF0F}, w);
    chk("sck period", SCK_DIV * INT_TICK_CYC, per);
    frame_end();
    host.deselect();
    for (int k = 0; k < 12; k++) begin
      repeat (50) @(posedge core_clk);
      rejection_select <= ~rejection_select;
    end
    @(negedge core_clk);
    chk1("osc found", 1'b1, ext_osc_active);
    repeat (DETC + 20) @(negedge core_clk);
    chk1("osc lost", 1'b0, ext_osc_active);
    tally_and_finish();
  end
endmodule : adcsr_ctrl_tb
